// >>> design/gpc_pkg.sv
// Shared constants, types and helper functions of the pin control port
`default_nettype none

package gpc_pkg;

  // Port geometry
  localparam int NPIN_DOC = 30;
  localparam int NFUNC    = 10;
  localparam int ADDR_W   = 8;

  // Function select codes
  localparam logic [4:0] FUNC_PORT = 5'h05;
  localparam logic [4:0] FUNC_NULL = 5'h1f;

  // Interrupt event bit positions
  localparam int EV_LOW  = 0;
  localparam int EV_HIGH = 1;
  localparam int EV_FALL = 2;
  localparam int EV_RISE = 3;

  // Override codes
  localparam logic [1:0] OVR_NORM = 2'h0;
  localparam logic [1:0] OVR_INV  = 2'h1;
  localparam logic [1:0] OVR_LOW  = 2'h2;
  localparam logic [1:0] OVR_HIGH = 2'h3;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_OUT     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OUT_SET = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OUT_CLR = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OUT_XOR = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DIR     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_DIR_SET = 8'h14;
  localparam logic [ADDR_W-1:0] REG_DIR_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] REG_IN      = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_MASK    = 8'h20;
  localparam logic [ADDR_W-1:0] REG_OUT_MSK = 8'h24;
  localparam logic [ADDR_W-1:0] REG_DIR_MSK = 8'h28;
  localparam logic [ADDR_W-1:0] REG_PUT     = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_SEL     = 8'h30;
  localparam logic [ADDR_W-1:0] REG_CFG     = 8'h34;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN  = 8'h38;
  localparam logic [ADDR_W-1:0] REG_IRQ_ST  = 8'h3c;
  localparam logic [ADDR_W-1:0] REG_IRQ_SUM = 8'h40;

  // Field positions
  localparam int PUT_VAL_BIT = 8;
  localparam int DORM_EN_LSB = 4;

  // Reset values
  localparam logic [31:0] OUT_RST  = 32'h0000_0000;
  localparam logic [31:0] DIR_RST  = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Per-pin pad and mux configuration
  typedef struct packed {
    logic [1:0] drive;
    logic       slew;
    logic       schmitt;
    logic       ie;
    logic       pde;
    logic       pue;
    logic [1:0] irqover;
    logic [1:0] inover;
    logic [1:0] oeover;
    logic [1:0] outover;
    logic [4:0] funcsel;
  } gpc_cfg_t;

  localparam gpc_cfg_t CFG_RST = '{drive: 2'h1, slew: 1'b0, schmitt: 1'b1,
    ie: 1'b1, pde: 1'b0, pue: 1'b0, irqover: OVR_NORM, inover: OVR_NORM,
    oeover: OVR_NORM, outover: OVR_NORM, funcsel: FUNC_NULL};

  // One register write as handed over by the bus slave
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } gpc_wr_t;

  // Apply an override code to a signal
  function automatic logic ovr(input logic v, input logic [1:0] sel);
    case (sel)
      OVR_INV:  ovr = ~v;
      OVR_LOW:  ovr = 1'b0;
      OVR_HIGH: ovr = 1'b1;
      default:  ovr = v;
    endcase
  endfunction

  // Expand byte strobes into a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] strb);
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

`default_nettype wire

// >>> design/gpc_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`default_nettype none

module gpc_axil_slave
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Register side
  output gpc_wr_t                wr,
  output logic                   wr_go,
  input  wire logic              wr_err,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  logic aw_full_q;
  logic w_full_q;
  logic ar_take;

  // Address and data are caught independently, in either order
  assign s_awready = ~aw_full_q;
  assign s_wready  = ~w_full_q;
  assign wr_go     = aw_full_q & w_full_q & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  assign ar_take   = s_arvalid & s_arready;
  assign rd_addr   = s_araddr;

  // Write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OK;
      wr        <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full_q <= 1'b1;
        wr.addr   <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_full_q <= 1'b1;
        wr.data  <= s_wdata;
        wr.strb  <= s_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_err ? RESP_ERR : RESP_OK;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channels; data is captured as the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= RESP_OK;
    end else if (ar_take) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_err ? 32'h0000_0000 : rd_data;
      s_rresp  <= rd_err ? RESP_ERR : RESP_OK;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> design/gpc_pin_cell.sv
// One pin: overrides between function and pad, and event detection
`default_nettype none

module gpc_pin_cell
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Configuration
  input  wire gpc_cfg_t   cfg,
  input  wire logic [3:0] ien,
  input  wire logic [3:0] den,
  input  wire logic [3:0] ack,
  // Function and pad side
  input  wire logic       fo,
  input  wire logic       fe,
  input  wire logic       pin_in,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            in_val,
  // Events
  output logic [3:0]      stat,
  output logic            irq_p,
  output logic            irq_d
);

  logic prev_q;
  logic armed_q;
  logic fall_q;
  logic rise_q;
  logic fall_d;
  logic rise_d;

  // Overrides sit between the selected function and the pad
  assign pad_out = ovr(fo, cfg.outover);
  assign pad_oe  = ovr(fe, cfg.oeover);
  assign in_val  = ovr(pin_in & cfg.ie, cfg.inover);

  // Edges latch; a new edge wins over an acknowledge in the same cycle
  assign fall_d = (armed_q & prev_q & ~in_val) | (fall_q & ~ack[EV_FALL]);
  assign rise_d = (armed_q & ~prev_q & in_val) | (rise_q & ~ack[EV_RISE]);

  // Levels follow the pin, edges are sticky
  assign stat[EV_LOW]  = ~in_val;
  assign stat[EV_HIGH] = in_val;
  assign stat[EV_FALL] = fall_q;
  assign stat[EV_RISE] = rise_q;

  // Enabled events pass the interrupt override
  assign irq_p = ovr(|(stat & ien), cfg.irqover);
  assign irq_d = ovr(|(stat & den), cfg.irqover);

  // Edge state; no edge is seen in the first cycle after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
      fall_q  <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      prev_q  <= in_val;
      armed_q <= 1'b1;
      fall_q  <= fall_d;
      rise_q  <= rise_d;
    end
  end

endmodule

`default_nettype wire

// >>> design/gpc_port.sv
// Pin control port: output and direction words, pad setup, mux, events
//
// How it works
// - Set word drives high every pin whose bit is one.
// - Toggle word inverts every pin whose bit is one.
// - Masked output write sets masked pins to value bits, others untouched.
// - Whole-port output write updates the levels of all pins in strobed byte lanes at once.
// - Single-pin write clears pin when value false, sets otherwise.
// - Masked direction write switches masked pins together, others unchanged.
// - Separate set and clear direction words switch named pins only.
// - Four event types per pin: low, high, falling, rising.
// - Interrupt event enables are per pin.
// - Separate per-pin dormant wake enables drive the oscillator wake line.
// - Pin interrupt passes an override: normal, invert, low, high.
// - Output, output enable and input overrides between function and pad.
// - Pull-up and pull-down enables, settable together, readable back.
// - Input enable per pin; hysteresis resets enabled, can be disabled.
// - Drive strength and slew selections are settable and readable.
// - Function select chooses the single function owning each pin.
// - A function input fed by several pins sees their OR.
// - Drive strength is two bits, 0 weakest to 3 strongest.
`default_nettype none

module gpc_port
  import gpc_pkg::*;
#(
  parameter int NPIN = NPIN_DOC
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite register bus
  input  wire logic [ADDR_W-1:0]           s_awaddr,
  input  wire logic                        s_awvalid,
  output logic                             s_awready,
  input  wire logic [31:0]                 s_wdata,
  input  wire logic [3:0]                  s_wstrb,
  input  wire logic                        s_wvalid,
  output logic                             s_wready,
  output logic [1:0]                       s_bresp,
  output logic                             s_bvalid,
  input  wire logic                        s_bready,
  input  wire logic [ADDR_W-1:0]           s_araddr,
  input  wire logic                        s_arvalid,
  output logic                             s_arready,
  output logic [31:0]                      s_rdata,
  output logic [1:0]                       s_rresp,
  output logic                             s_rvalid,
  input  wire logic                        s_rready,
  // Pads
  input  wire logic [NPIN-1:0]             pad_in,
  output logic [NPIN-1:0]                  pad_out,
  output logic [NPIN-1:0]                  pad_oe,
  output logic [NPIN-1:0]                  pad_pue,
  output logic [NPIN-1:0]                  pad_pde,
  output logic [NPIN-1:0]                  pad_ie,
  output logic [NPIN-1:0]                  pad_schmitt,
  output logic [NPIN-1:0]                  pad_slew,
  output logic [NPIN-1:0][1:0]             pad_drive,
  // Peripheral functions
  input  wire logic [NFUNC-1:0][NPIN-1:0]  fn_out,
  input  wire logic [NFUNC-1:0][NPIN-1:0]  fn_oe,
  output logic [NFUNC-1:0][NPIN-1:0]       fn_in,
  output logic [NFUNC-1:0]                 fn_in_any,
  // Event outputs
  output logic                             irq_proc,
  output logic                             dormant_wake
);

  // Pin index and word width must fit the 32-bit registers
  if (NPIN < 1 || NPIN > 30) begin : g_chk
    $error("NPIN must lie between 1 and 30");
  end

  // True for every address that holds a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= REG_IRQ_SUM);
  endfunction

  // Registers
  logic [NPIN-1:0] out_q;
  logic [NPIN-1:0] out_d;
  logic [NPIN-1:0] dir_q;
  logic [NPIN-1:0] dir_d;
  logic [NPIN-1:0] mask_q;
  logic [4:0]      sel_q;
  gpc_cfg_t        cfg_q [NPIN];
  logic [3:0]      ien_q [NPIN];
  logic [3:0]      den_q [NPIN];

  // Pad input synchroniser
  logic [NPIN-1:0] in_s1_q;
  logic [NPIN-1:0] in_s2_q;

  // Bus side
  gpc_wr_t           wr;
  logic              wr_go;
  logic              wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;

  // Pin cell results
  logic [NPIN-1:0]      in_val;
  logic [NPIN-1:0]      irq_p;
  logic [NPIN-1:0]      irq_d;
  logic [3:0]           stat [NPIN];
  logic [NPIN-1:0][3:0] ack;

  gpc_axil_slave u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr        (wr),
    .wr_go     (wr_go),
    .wr_err    (wr_err),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_err    (rd_err)
  );

  // Write decode; lanes not strobed carry zero bits
  logic [31:0] wd;
  logic [31:0] wm;
  logic        we_out, we_set, we_clr, we_xor, we_dir;
  logic        we_dset, we_dclr, we_mask, we_omsk, we_dmsk;
  logic        we_put, we_sel, we_cfg, we_ien, we_ack;
  logic        put_ok;
  logic [4:0]  put_idx;

  assign wm      = lanes(wr.strb);
  assign wd      = wr.data & wm;
  assign wr_err  = ~is_mapped(wr.addr) || (wr.addr == REG_IN) || (wr.addr == REG_IRQ_SUM);
  assign rd_err  = ~is_mapped(rd_addr);
  assign we_out  = wr_go && (wr.addr == REG_OUT);
  assign we_set  = wr_go && (wr.addr == REG_OUT_SET);
  assign we_clr  = wr_go && (wr.addr == REG_OUT_CLR);
  assign we_xor  = wr_go && (wr.addr == REG_OUT_XOR);
  assign we_dir  = wr_go && (wr.addr == REG_DIR);
  assign we_dset = wr_go && (wr.addr == REG_DIR_SET);
  assign we_dclr = wr_go && (wr.addr == REG_DIR_CLR);
  assign we_mask = wr_go && (wr.addr == REG_MASK);
  assign we_omsk = wr_go && (wr.addr == REG_OUT_MSK);
  assign we_dmsk = wr_go && (wr.addr == REG_DIR_MSK);
  assign we_put  = wr_go && (wr.addr == REG_PUT);
  assign we_sel  = wr_go && (wr.addr == REG_SEL);
  assign we_cfg  = wr_go && (wr.addr == REG_CFG);
  assign we_ien  = wr_go && (wr.addr == REG_IRQ_EN);
  assign we_ack  = wr_go && (wr.addr == REG_IRQ_ST);
  assign put_idx = wr.data[4:0];
  assign put_ok  = we_put && wr.strb[0] && (put_idx < 5'(NPIN));

  // Output level: fixed order whole, masked, set, clear, toggle, single
  always_comb begin
    out_d = out_q;
    if (we_out) begin
      out_d = (out_q & ~wm[NPIN-1:0]) | wd[NPIN-1:0];
    end
    if (we_omsk) begin
      out_d = (out_d & ~mask_q) | (wd[NPIN-1:0] & mask_q);
    end
    if (we_set) begin
      out_d = out_d | wd[NPIN-1:0];
    end
    if (we_clr) begin
      out_d = out_d & ~wd[NPIN-1:0];
    end
    if (we_xor) begin
      out_d = out_d ^ wd[NPIN-1:0];
    end
    if (put_ok) begin
      out_d[put_idx] = wr.data[PUT_VAL_BIT];
    end
  end

  // Direction: fixed order whole, masked, set, clear
  always_comb begin
    dir_d = dir_q;
    if (we_dir) begin
      dir_d = (dir_q & ~wm[NPIN-1:0]) | wd[NPIN-1:0];
    end
    if (we_dmsk) begin
      dir_d = (dir_d & ~mask_q) | (wd[NPIN-1:0] & mask_q);
    end
    if (we_dset) begin
      dir_d = dir_d | wd[NPIN-1:0];
    end
    if (we_dclr) begin
      dir_d = dir_d & ~wd[NPIN-1:0];
    end
  end

  // Port words and selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q  <= OUT_RST[NPIN-1:0];
      dir_q  <= DIR_RST[NPIN-1:0];
      mask_q <= MASK_RST[NPIN-1:0];
      sel_q  <= 5'h00;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
      if (we_mask) begin
        mask_q <= (mask_q & ~wm[NPIN-1:0]) | wd[NPIN-1:0];
      end
      if (we_sel && wr.strb[0] && wr.data[4:0] < 5'(NPIN)) begin
        sel_q <= wr.data[4:0];
      end
    end
  end

  // Per-pin configuration of the selected pin
  gpc_cfg_t cfg_wr;
  logic [3:0] ien_wr;
  logic [3:0] den_wr;

  assign cfg_wr = gpc_cfg_t'(20'((32'(cfg_q[sel_q]) & ~wm) | wd));
  assign ien_wr = wr.strb[0] ? wr.data[3:0] : ien_q[sel_q];
  assign den_wr = wr.strb[0] ? wr.data[DORM_EN_LSB +: 4] : den_q[sel_q];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NPIN; i++) begin
        cfg_q[i] <= CFG_RST;
        ien_q[i] <= 4'h0;
        den_q[i] <= 4'h0;
      end
    end else begin
      if (we_cfg) begin
        cfg_q[sel_q] <= cfg_wr;
      end
      if (we_ien) begin
        ien_q[sel_q] <= ien_wr;
        den_q[sel_q] <= den_wr;
      end
    end
  end

  // Two flip-flops before logic reads the pads; no reset, so no false edge
  always_ff @(posedge aclk) begin
    in_s1_q <= pad_in;
    in_s2_q <= in_s1_q;
  end

  // Pins: function select, pad controls and event cells
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic       fo;
    logic       fe;
    logic [4:0] fs;

    assign fs = cfg_q[i].funcsel;
    assign fo = (fs == FUNC_PORT) ? out_q[i] :
                (fs < 5'(NFUNC)) ? fn_out[fs][i] : 1'b0;
    assign fe = (fs == FUNC_PORT) ? dir_q[i] :
                (fs < 5'(NFUNC)) ? fn_oe[fs][i] : 1'b0;
    assign ack[i] = (we_ack && wr.strb[0] && sel_q == 5'(i)) ? wr.data[3:0] : 4'h0;

    assign pad_pue[i]     = cfg_q[i].pue;
    assign pad_pde[i]     = cfg_q[i].pde;
    assign pad_ie[i]      = cfg_q[i].ie;
    assign pad_schmitt[i] = cfg_q[i].schmitt;
    assign pad_slew[i]    = cfg_q[i].slew;
    assign pad_drive[i]   = cfg_q[i].drive;

    for (genvar f = 0; f < NFUNC; f++) begin : g_fn
      assign fn_in[f][i] = in_val[i] & (fs == 5'(f));
    end

    gpc_pin_cell u_cell (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (cfg_q[i]),
      .ien     (ien_q[i]),
      .den     (den_q[i]),
      .ack     (ack[i]),
      .fo      (fo),
      .fe      (fe),
      .pin_in  (in_s2_q[i]),
      .pad_out (pad_out[i]),
      .pad_oe  (pad_oe[i]),
      .in_val  (in_val[i]),
      .stat    (stat[i]),
      .irq_p   (irq_p[i]),
      .irq_d   (irq_d[i])
    );
  end

  // A function input routed from several pins sees their OR
  for (genvar f = 0; f < NFUNC; f++) begin : g_any
    assign fn_in_any[f] = |fn_in[f];
  end

  // Combined event lines
  assign irq_proc     = |irq_p;
  assign dormant_wake = |irq_d;

  // Read data
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      REG_OUT:     rd_data[NPIN-1:0] = out_q;
      REG_DIR:     rd_data[NPIN-1:0] = dir_q;
      REG_IN:      rd_data[NPIN-1:0] = in_s2_q;
      REG_MASK:    rd_data[NPIN-1:0] = mask_q;
      REG_SEL:     rd_data[4:0] = sel_q;
      REG_CFG:     rd_data = 32'(cfg_q[sel_q]);
      REG_IRQ_EN:  rd_data[7:0] = {den_q[sel_q], ien_q[sel_q]};
      REG_IRQ_ST:  rd_data[3:0] = stat[sel_q];
      REG_IRQ_SUM: rd_data[NPIN-1:0] = irq_p;
      default:     rd_data = 32'h0000_0000;
    endcase
  end

endmodule

`default_nettype wire

// >>> testbench/gpc_port_asserts.sv
// Bus, reset and mux checks of the pin control port
`default_nettype none

module gpc_port_chk
  import gpc_pkg::*;
#(
  parameter int NPIN = 30
) (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Register bus
  input wire logic                       s_awvalid,
  input wire logic                       s_awready,
  input wire logic                       s_wready,
  input wire logic                       s_bvalid,
  input wire logic                       s_bready,
  input wire logic                       s_arvalid,
  input wire logic                       s_arready,
  input wire logic                       s_rvalid,
  input wire logic                       s_rready,
  // Pads, functions, events
  input wire logic [NPIN-1:0]            pad_oe,
  input wire logic [NPIN-1:0]            pad_schmitt,
  input wire logic [NPIN-1:0][1:0]       pad_drive,
  input wire logic [NFUNC-1:0][NPIN-1:0] fn_in,
  input wire logic [NFUNC-1:0]           fn_in_any,
  input wire logic                       irq_proc
);
  // OR of each function's pins
  logic [NFUNC-1:0] any_w;
  always_comb for (int f = 0; f < NFUNC; f++) any_w[f] = |fn_in[f];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Answers stand until taken; one transfer each way
  a_bvalid_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_rvalid && !s_rready |=> s_rvalid)
    else $error("read data dropped early");
  a_read_block: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while busy");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_addr_busy: assert property (s_awvalid && s_awready |=> !s_awready)
    else $error("address taken twice");
  a_resp_order: assert property ($rose(s_bvalid) |-> !$past(s_awready) && !$past(s_wready))
    else $error("response before address and data");
  a_any_or: assert property (fn_in_any == any_w)
    else $error("function input not OR of pins");
  a_reset_pads: assert property ($rose(aresetn) |->
    pad_schmitt == '1 && pad_oe == '0 && pad_drive == {NPIN{2'h1}} && !irq_proc)
    else $error("pad settings wrong after reset");
endmodule

bind gpc_port gpc_port_chk #(.NPIN(NPIN)) i_gpc_port_chk (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready), .pad_oe(pad_oe),
  .pad_schmitt(pad_schmitt), .pad_drive(pad_drive), .fn_in(fn_in),
  .fn_in_any(fn_in_any), .irq_proc(irq_proc));

`default_nettype wire

// >>> testbench/gpc_pad_world.sv
// Pad model: own drive, outside drivers, pulls
`default_nettype none

module gpc_pad_world #(
  parameter int NPIN = 30
) (
  // Clock
  input  wire logic [0:0]      aclk,
  // Pad controls from the port
  input  wire logic [NPIN-1:0] pad_out,
  input  wire logic [NPIN-1:0] pad_oe,
  input  wire logic [NPIN-1:0] pad_pue,
  input  wire logic [NPIN-1:0] pad_pde,
  // Outside drivers
  input  wire logic [NPIN-1:0] ext_val,
  input  wire logic [NPIN-1:0] ext_en,
  // Level seen at each pad
  output logic      [NPIN-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NPIN-1:0] last_q;

  // A floating pad never shows a stable last value
  always_ff @(posedge aclk) last_q <= pad_in;

  // Own drive, then outside driver, then pulls
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pue[i]) pad_in[i] = 1'b1;
      else if (pad_pde[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~last_q[i];
    end
  end
endmodule

`default_nettype wire

// >>> testbench/gpc_port_test.sv
// Self-checking bench of the pin control port
`default_nettype none

module gpc_port_test
  import gpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] C5 = 32'h0005_8005;
  localparam logic [7:0] OPA [10] = '{REG_OUT, REG_OUT_SET, REG_OUT_CLR, REG_OUT_XOR,
    REG_OUT_MSK, REG_PUT, REG_DIR, REG_DIR_SET, REG_DIR_CLR, REG_DIR_MSK};
  localparam int OPK [10] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 4};
  // Bus side, pads and function lines
  logic                   aclk = 0, aresetn = 0, aw = 0, w = 0, b = 0, ar = 0, r = 0;
  logic                   awr, wrdy, bv, arr, rv, irq, wake, sn_irq, sn_wake;
  logic [7:0]             awa = 0, ara = 0;
  logic [1:0]             br, rr;
  logic [31:0]            wd = 0, rdat, eo = 0, ed = 0, ev, m;
  logic [29:0]            ext = 0, po, poe, pin, pue, pde, sn_out, sn_oe;
  logic [NFUNC-1:0][29:0] fo = '0, fe = '0;
  int                     error_cnt = 0, n_tests = 0, op;

  gpc_port #(.NPIN(30)) i_gpc_port (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awa),
    .s_awvalid(aw), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hf), .s_wvalid(w),
    .s_wready(wrdy), .s_bresp(br), .s_bvalid(bv), .s_bready(b), .s_araddr(ara),
    .s_arvalid(ar), .s_arready(arr), .s_rdata(rdat), .s_rresp(rr), .s_rvalid(rv),
    .s_rready(r), .pad_in(pin), .pad_out(po), .pad_oe(poe), .pad_pue(pue),
    .pad_pde(pde), .pad_ie(), .pad_schmitt(), .pad_slew(), .pad_drive(),
    .fn_out(fo), .fn_oe(fe), .fn_in(), .fn_in_any(), .irq_proc(irq),
    .dormant_wake(wake));
  gpc_pad_world i_gpc_pad_world (.aclk(aclk), .pad_out(po), .pad_oe(poe),
    .pad_pue(pue), .pad_pde(pde), .ext_val(ext), .ext_en({30{1'b1}}), .pad_in(pin));

  // 125 MHz clock; outputs sampled mid-cycle
  always #4 aclk = ~aclk;
  always @(negedge aclk) {sn_wake, sn_irq, sn_oe, sn_out} <= {wake, irq, poe, po};

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Write one word and check its response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OK);
    logic ta, tw, tb;
    awa <= a;
    wd <= d;
    aw <= 1'b1;
    w <= 1'b1;
    do begin
      @(negedge aclk);
      ta = aw & awr;
      tw = w & wrdy;
      tb = bv & b;
      if (tb) cmp("bresp", 32'(e), 32'(br));
      @(posedge aclk);
      if (ta) aw <= 1'b0;
      if (tw) w <= 1'b0;
      b <= bv & !tb;
    end while (!tb);
  endtask

  // Read one word, check it and its response
  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] s = RESP_OK);
    logic ta, tr;
    ara <= a;
    ar <= 1'b1;
    do begin
      @(negedge aclk);
      ta = ar & arr;
      tr = rv & r;
      if (tr) cmp("rresp", 32'(s), 32'(rr));
      if (tr) cmp(n, e, rdat);
      @(posedge aclk);
      if (ta) ar <= 1'b0;
      r <= rv & !tr;
    end while (!tr);
  endtask

  // Expected word after a port write
  function automatic logic [31:0] upd(int k, logic [31:0] c, d, mk);
    case (k)
      0: return d;
      1: return c | d;
      2: return c & ~d;
      3: return c ^ d;
      4: return (c & ~mk) | (d & mk);
      default: return d[8] ? c | (32'h1 << d[4:0]) : c & ~(32'h1 << d[4:0]);
    endcase
  endfunction

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Well past the run's length
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(88));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("out", REG_OUT, 32'h0);
    chk("cfg", REG_CFG, 32'h0005_801f);
    for (int i = 0; i < 30; i++) begin
      wr(REG_SEL, i);
      wr(REG_CFG, C5);
    end
    repeat (60) begin
      op = $urandom_range(9);
      ev = $urandom & 32'h3fff_ffff;
      m = $urandom & 32'h3fff_ffff;
      if (op == 5) ev = (ev & 32'h100) | $urandom_range(29);
      if (OPK[op] == 4) wr(REG_MASK, m);
      wr(OPA[op], ev);
      if (op < 6) eo = upd(OPK[op], eo, ev, m);
      else ed = upd(OPK[op], ed, ev, m);
      ext <= 30'($urandom);
      chk("out", REG_OUT, eo);
      chk("dir", REG_DIR, ed);
      cmp("pad_out", eo, 32'(sn_out));
      cmp("pad_oe", ed, 32'(sn_oe));
      chk("in", REG_IN, (eo & ed) | (32'(ext) & ~ed));
    end
    wr(REG_DIR, 32'h0);
    ext <= '0;
    wr(REG_SEL, 32'h3);
    wr(REG_IRQ_ST, 32'hc);
    wr(REG_IRQ_EN, 32'h8);
    ext <= 30'h8;
    repeat (5) @(posedge aclk);
    cmp("irq", 32'h1, {31'b0, sn_irq});
    chk("st", REG_IRQ_ST, 32'ha);
    wr(REG_IRQ_ST, 32'h8);
    chk("st", REG_IRQ_ST, 32'h2);
    cmp("irq", 32'h0, {31'b0, sn_irq});
    wr(REG_IRQ_EN, 32'h22);
    cmp("irq", 32'h1, {31'b0, sn_irq});
    cmp("wake", 32'h1, {31'b0, sn_wake});
    wr(REG_IRQ_EN, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(REG_CFG, C5 | (c << 11));
      cmp("irq", {31'b0, c[0]}, {31'b0, sn_irq});
    end
    wr(REG_IRQ_EN, 32'h4);
    ext <= '0;
    repeat (5) @(posedge aclk);
    chk("st", REG_IRQ_ST, 32'h5);
    wr(REG_IRQ_ST, 32'h5);
    chk("st", REG_IRQ_ST, 32'h1);
    fo[2] <= 30'($urandom);
    fe[2] <= 30'($urandom);
    wr(REG_SEL, 32'h4);
    wr(REG_CFG, 32'h0005_8022);
    cmp("fn_out", {31'b0, ~fo[2][4]}, {31'b0, sn_out[4]});
    cmp("fn_oe", {31'b0, fe[2][4]}, {31'b0, sn_oe[4]});
    wr(REG_CFG, 32'h000a_e005);
    chk("cfg", REG_CFG, 32'h000a_e005);
    chk("bad", 8'h44, 32'h0, RESP_ERR);
    wr(REG_IN, 32'h1, RESP_ERR);
    close_out();
  end
endmodule

`default_nettype wire
